// ===== rtl/sbo_core.sv
`include "sbo_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module sbo_core (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // bus framer events
  input  wire sbo_pkg::sbo_tx_ev_t tx_ev,
  input  wire sbo_pkg::sbo_rx_ev_t rx_ev,
  // framer controls and interrupt
  output logic                   tx_extra,
  output logic                   tx_end,
  output logic                   rx_wait,
  output logic                   irq
);
  localparam logic [10:0] WAIT_LIM = 11'(`SBO_WAIT_CYC);

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction : inc8

  logic [7:0]  maxb_r, txlen_r;
  logic [6:0]  stat_r, mask_r, set_v, clr_v;
  sbo_pkg::sbo_tx_st_t tx_st_r, tx_st_nxt;
  sbo_pkg::sbo_rx_st_t rx_st_r, rx_st_nxt;
  logic [7:0]  tx_cnt_r, tx_sent_r, rx_cnt_r, rx_got_r;
  logic        rx_par_r;
  logic [10:0] wait_cnt_r;
  logic        aw_hold_r, w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // ---------------- transmit side
  wire [7:0] tx_cnt_inc  = inc8(tx_cnt_r);
  wire [7:0] tx_sent_inc = inc8(tx_sent_r);
  wire tx_run_done = (tx_st_r == sbo_pkg::TX_RUN) && tx_ev.done;
  wire tx_ok_end   = tx_run_done && tx_ev.ack && (tx_sent_inc == txlen_r);
  wire tx_limit    = tx_run_done && !tx_ok_end && (tx_cnt_inc == maxb_r);
  wire tx_x_done   = (tx_st_r == sbo_pkg::TX_EXTRA) && tx_ev.done;

  always_comb begin
    tx_st_nxt = tx_st_r;
    case (tx_st_r)
      sbo_pkg::TX_IDLE:  if (tx_ev.start) tx_st_nxt = sbo_pkg::TX_RUN;
      sbo_pkg::TX_RUN: begin
        if (tx_ok_end) tx_st_nxt = sbo_pkg::TX_IDLE;
        else if (tx_limit) tx_st_nxt = sbo_pkg::TX_EXTRA;
      end
      sbo_pkg::TX_EXTRA: if (tx_ev.done) tx_st_nxt = sbo_pkg::TX_IDLE;
      default: tx_st_nxt = sbo_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st_r   <= sbo_pkg::TX_IDLE;
      tx_cnt_r  <= 8'h00;
      tx_sent_r <= 8'h00;
    end else begin
      tx_st_r <= tx_st_nxt;
      if (tx_st_r == sbo_pkg::TX_IDLE) begin
        tx_cnt_r  <= 8'h00;
        tx_sent_r <= 8'h00;
      end else if (tx_run_done) begin
        tx_cnt_r <= tx_cnt_inc;
        if (tx_ev.ack) tx_sent_r <= tx_sent_inc;
      end
    end
  end

  // ---------------- receive side
  wire [7:0] rx_cnt_inc = inc8(rx_cnt_r);
  wire [7:0] rx_got_inc = inc8(rx_got_r);
  wire rx_good     = !rx_ev.par_err && !rx_ev.ovr_err;
  wire rx_run_done = (rx_st_r == sbo_pkg::RX_RUN) && rx_ev.done;
  wire rx_ok_end   = rx_run_done && rx_good && (rx_got_inc == rx_ev.msg_len);
  wire rx_limit    = rx_run_done && !rx_ok_end && (rx_cnt_inc == maxb_r);
  wire rx_x_done   = (rx_st_r == sbo_pkg::RX_WAIT) && rx_ev.done;
  wire rx_timeout  = (rx_st_r == sbo_pkg::RX_WAIT) && !rx_ev.done
                     && (wait_cnt_r == WAIT_LIM - 11'h001);

  always_comb begin
    rx_st_nxt = rx_st_r;
    case (rx_st_r)
      sbo_pkg::RX_IDLE: if (rx_ev.start) rx_st_nxt = sbo_pkg::RX_RUN;
      sbo_pkg::RX_RUN: begin
        if (rx_ok_end) rx_st_nxt = sbo_pkg::RX_IDLE;
        else if (rx_limit) rx_st_nxt = sbo_pkg::RX_WAIT;
      end
      sbo_pkg::RX_WAIT: begin
        if (rx_ev.done || rx_timeout) rx_st_nxt = sbo_pkg::RX_IDLE;
      end
      default: rx_st_nxt = sbo_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_r    <= sbo_pkg::RX_IDLE;
      rx_cnt_r   <= 8'h00;
      rx_got_r   <= 8'h00;
      rx_par_r   <= 1'b0;
      wait_cnt_r <= 11'h000;
    end else begin
      rx_st_r <= rx_st_nxt;
      if (rx_st_r == sbo_pkg::RX_IDLE) begin
        rx_cnt_r <= 8'h00;
        rx_got_r <= 8'h00;
      end else if (rx_run_done) begin
        rx_cnt_r <= rx_cnt_inc;
        if (rx_good) rx_got_r <= rx_got_inc;
      end
      // remember whether the limit byte left a parity error standing
      if (rx_limit) rx_par_r <= rx_ev.par_err;
      if (rx_st_r == sbo_pkg::RX_WAIT) wait_cnt_r <= wait_cnt_r + 11'h001;
      else wait_cnt_r <= 11'h000;
    end
  end

  // ---------------- status events, set wins over clear
  always_comb begin
    set_v = 7'h00;
    set_v[`SBO_ST_TXERR] = tx_limit;
    set_v[`SBO_ST_TXOVR] = tx_x_done && !tx_ev.ack;
    set_v[`SBO_ST_TXFIN] = tx_ok_end || (tx_x_done && tx_ev.ack);
    set_v[`SBO_ST_RXERR] = rx_limit;
    set_v[`SBO_ST_RXTIM] = rx_timeout;
    set_v[`SBO_ST_RXLEN] = rx_x_done && !rx_par_r;
    set_v[`SBO_ST_RXPAR] = rx_x_done && rx_par_r;
  end

  // ---------------- axi4-lite slave
  wire wr_go  = aw_hold_r && w_hold_r && !s_axi_bvalid;
  wire wr_map = (awaddr_r == `SBO_OFF_MAXB) || (awaddr_r == `SBO_OFF_TXLEN)
                || (awaddr_r == `SBO_OFF_STAT) || (awaddr_r == `SBO_OFF_MASK);
  wire rd_go  = s_axi_arvalid && s_axi_arready;
  wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
  wire rd_map = (ra == `SBO_OFF_MAXB) || (ra == `SBO_OFF_TXLEN)
                || (ra == `SBO_OFF_STAT) || (ra == `SBO_OFF_MASK)
                || (ra == `SBO_OFF_STATE);
  wire [31:0] rd_val =
      (ra == `SBO_OFF_MAXB)  ? {24'h000000, maxb_r} :
      (ra == `SBO_OFF_TXLEN) ? {24'h000000, txlen_r} :
      (ra == `SBO_OFF_STAT)  ? {25'h0000000, stat_r} :
      (ra == `SBO_OFF_MASK)  ? {25'h0000000, mask_r} :
      (ra == `SBO_OFF_STATE) ? {28'h0000000, rx_st_r, tx_st_r} : 32'h00000000;
  wire st_wr = wr_go && (awaddr_r == `SBO_OFF_STAT) && wstrb_r[0];
  assign clr_v = st_wr ? wdata_r[6:0] : 7'h00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
      s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_map ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------- registers and outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      maxb_r   <= `SBO_MAXB_RST;
      txlen_r  <= `SBO_TXLEN_RST;
      mask_r   <= `SBO_MASK_RST;
      stat_r   <= 7'h00;
      tx_extra <= 1'b0;
      tx_end   <= 1'b0;
      rx_wait  <= 1'b0;
      irq      <= 1'b0;
    end else begin
      if (wr_go && wstrb_r[0]) begin
        if (awaddr_r == `SBO_OFF_MAXB)  maxb_r  <= wdata_r[7:0];
        if (awaddr_r == `SBO_OFF_TXLEN) txlen_r <= wdata_r[7:0];
        if (awaddr_r == `SBO_OFF_MASK)  mask_r  <= wdata_r[6:0];
      end
      stat_r   <= (stat_r & ~clr_v) | set_v;
      tx_extra <= (tx_st_nxt == sbo_pkg::TX_EXTRA);
      tx_end   <= tx_ok_end || tx_x_done;
      rx_wait  <= (rx_st_nxt == sbo_pkg::RX_WAIT);
      irq      <= |(((stat_r & ~clr_v) | set_v) & mask_r);
    end
  end

  // ---------------- assertions
  // cycles waited for the extra rx byte, counted apart from the fsm
  localparam logic [11:0] WAIT_SEEN = 12'(`SBO_WAIT_CYC);
  logic [11:0] wt_seen_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wt_seen_r <= 12'h000;
    end else if (rx_wait && !rx_ev.done) begin
      wt_seen_r <= wt_seen_r + 12'h001;
    end else begin
      wt_seen_r <= 12'h000;
    end
  end

  sequence tx_enter_s;
    tx_limit;
  endsequence
  sequence tx_nak_s;
    tx_x_done && !tx_ev.ack;
  endsequence
  sequence rx_enter_s;
    rx_limit;
  endsequence
  // extra byte steps: ack on tx, parity limit then arrival on rx
  sequence tx_ack_s;
    tx_x_done && tx_ev.ack;
  endsequence
  sequence rx_par_s;
    rx_limit && rx_ev.par_err ##[1:4] rx_x_done;
  endsequence

  tx_err_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_enter_s |=> stat_r[`SBO_ST_TXERR] && tx_st_r == sbo_pkg::TX_EXTRA && tx_extra)
    else $error("tx limit did not flag error and wait");
  tx_one_extra_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_x_done |=> tx_end && !tx_extra && tx_st_r == sbo_pkg::TX_IDLE)
    else $error("tx extra byte did not end transfer");
  tx_nak_ovr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_nak_s |=> stat_r[`SBO_ST_TXOVR] && !$rose(stat_r[`SBO_ST_TXFIN]))
    else $error("nak on extra byte missed overrun flag");
  tx_ack_fin_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_ack_s |=> stat_r[`SBO_ST_TXFIN] && !$rose(stat_r[`SBO_ST_TXOVR]))
    else $error("ack on extra byte missed finished flag");
  rx_err_wait_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_enter_s |=> stat_r[`SBO_ST_RXERR] && rx_wait ##1 rx_wait)
    else $error("rx limit did not flag error and wait");
  rx_wait_bound_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wt_seen_r <= WAIT_SEEN)
    else $error("rx wait outlasted the extra byte window");
  rx_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
    wt_seen_r == WAIT_SEEN |-> stat_r[`SBO_ST_RXTIM] && !rx_wait)
    else $error("missing extra rx byte not timed out");
  rx_tim_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_timeout |=> rx_st_r == sbo_pkg::RX_IDLE && !$rose(stat_r[`SBO_ST_RXLEN])
    && !$rose(stat_r[`SBO_ST_RXPAR]))
    else $error("timeout set length or parity flag");
  rx_par_arr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_par_s |=> stat_r[`SBO_ST_RXPAR])
    else $error("parity flag not set on extra byte");
  rx_len_arr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(stat_r[`SBO_ST_RXLEN]) |-> $past(rx_st_r) == sbo_pkg::RX_WAIT && $past(rx_ev.done))
    else $error("length flag set without extra byte");
  rx_ok_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_ok_end |=> !rx_wait && !$rose(stat_r[`SBO_ST_RXERR]))
    else $error("complete rx message raised the error flag");
  rx_wait_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_x_done |=> !rx_wait && rx_st_r == sbo_pkg::RX_IDLE)
    else $error("rx wait did not end on the extra byte");
  tx_ok_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_ok_end |=> tx_end && !tx_extra && !$rose(stat_r[`SBO_ST_TXERR]))
    else $error("complete tx message raised the error flag");

  // checks on the register bus and the interrupt
  irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !$changed(mask_r) |-> irq == |(stat_r & mask_r))
    else $error("irq does not follow unmasked status");
  aw_one_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address accepted while one is held");
  w_one_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("write data accepted while one is held");
  ar_one_held_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read address accepted while one is held");
  b_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response dropped before bready");
  r_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data dropped before rready");
endmodule : sbo_core
`default_nettype wire

// ===== rtl/sbo_pkg.sv
package sbo_pkg;
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_RUN   = 2'b01,
    TX_EXTRA = 2'b10
  } sbo_tx_st_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_RUN  = 2'b01,
    RX_WAIT = 2'b10
  } sbo_rx_st_t;
  typedef struct packed {
    logic start;
    logic done;
    logic ack;
  } sbo_tx_ev_t;
  typedef struct packed {
    logic       start;
    logic       done;
    logic       par_err;
    logic       ovr_err;
    logic [7:0] msg_len;
  } sbo_rx_ev_t;
endpackage : sbo_pkg

// ===== rtl/sbo_regs.svh
`ifndef SBO_REGS_SVH
`define SBO_REGS_SVH
// register byte offsets
`define SBO_OFF_MAXB  8'h00
`define SBO_OFF_TXLEN 8'h04
`define SBO_OFF_STAT  8'h08
`define SBO_OFF_MASK  8'h0C
`define SBO_OFF_STATE 8'h10
// reset values
`define SBO_MAXB_RST  8'h20
`define SBO_TXLEN_RST 8'h01
`define SBO_MASK_RST  7'h00
// status bit positions
`define SBO_ST_TXERR 0
`define SBO_ST_TXOVR 1
`define SBO_ST_TXFIN 2
`define SBO_ST_RXERR 3
`define SBO_ST_RXTIM 4
`define SBO_ST_RXLEN 5
`define SBO_ST_RXPAR 6
// extra receive byte wait
`define SBO_WAIT_NS  8000
`define SBO_CLK_MHZ  250
`define SBO_WAIT_CYC ((`SBO_WAIT_NS * `SBO_CLK_MHZ + 999) / 1000)
`endif

// ===== testbench/sbo_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
module sbo_framer_model (
  // clock
  input  wire logic               aclk,
  // framer events
  output var sbo_pkg::sbo_tx_ev_t tx_ev,
  output var sbo_pkg::sbo_rx_ev_t rx_ev
);
  initial begin
    tx_ev = '0;
    rx_ev = '0;
  end
  // one-cycle pulse; qualifiers scrambled once done drops
  task automatic tx_send(input logic st, input logic ack);
    @(posedge aclk);
    tx_ev <= {st, !st, ack};
    @(posedge aclk);
    tx_ev <= {2'b00, !ack};
  endtask : tx_send
  // code bit 0 parity error, bit 1 overrun error
  task automatic rx_send(input logic st, input logic [1:0] code, input logic [7:0] len);
    @(posedge aclk);
    rx_ev <= {st, !st, code[0], code[1], len};
    @(posedge aclk);
    rx_ev <= {2'b00, ~code[0], ~code[1], len};
  endtask : rx_send
endmodule : sbo_framer_model
`default_nettype wire

// ===== testbench/serial_bus_max_byte_overrun_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, s); end end
module serial_bus_max_byte_overrun_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        tx_extra, tx_end, rx_wait, irq;
  logic [1:0]  bresp, rresp, rs;
  logic [31:0] rdata, rd;
  sbo_pkg::sbo_tx_ev_t tx_ev;
  sbo_pkg::sbo_rx_ev_t rx_ev;
  int          num_errors = 0;
  int          tests_run = 0;
  int          tx_end_cnt = 0;
  always #2 aclk = ~aclk;
  always @(posedge aclk)
    if (tx_end) tx_end_cnt++;
  sbo_core dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_ev(tx_ev), .rx_ev(rx_ev), .tx_extra(tx_extra),
    .tx_end(tx_end), .rx_wait(rx_wait), .irq(irq));
  sbo_framer_model fm_u (.aclk(aclk), .tx_ev(tx_ev), .rx_ev(rx_ev));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rdreg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rdreg
  // mask holds bit 0 only, so irq follows the tx error bit
  task automatic chk_stat(input logic [31:0] e);
    rdreg(8'h08);
    `CHK("stat", e, rd)
    `CHK("irq", e[0], irq)
    wr(8'h08, 32'h7F);
    repeat (2) @(posedge aclk);
    `CHK("irq clr", 1'b0, irq)
    rdreg(8'h08);
    `CHK("stat clr", 32'h0, rd)
  endtask : chk_stat
  function automatic logic [31:0] tx_model(int maxb, int len, int acks[$]);
    int c = 0;
    int ok = 0;
    foreach (acks[i]) begin
      if (c == maxb) return acks[i] ? 32'h5 : 32'h3;
      c++;
      ok += acks[i];
      if (ok == len) return 32'h4;
    end
    return (c == maxb) ? 32'h1 : 32'h0;
  endfunction : tx_model
  function automatic logic [31:0] rx_model(int maxb, int len, int codes[$], bit late);
    int c = 0;
    int good = 0;
    bit par = 1'b0;
    foreach (codes[i]) begin
      if (c == maxb) return par ? 32'h48 : 32'h28;
      c++;
      good += (codes[i] == 0);
      par = (codes[i] == 1);
      if (good == len) return 32'h0;
    end
    return (c == maxb) ? (late ? 32'h18 : 32'h08) : 32'h0;
  endfunction : rx_model
  task automatic tx_run(int acks[$]);
    fm_u.tx_send(1'b1, 1'b0);
    foreach (acks[i]) fm_u.tx_send(1'b0, acks[i][0]);
    repeat (2) @(posedge aclk);
  endtask : tx_run
  task automatic rx_run(int codes[$], bit late, logic [7:0] len);
    fm_u.rx_send(1'b1, 2'b00, len);
    foreach (codes[i]) fm_u.rx_send(1'b0, codes[i][1:0], len);
    repeat (2) @(posedge aclk);
    if (late) repeat (2010) @(posedge aclk);
    chk_stat(rx_model(2, len, codes, late));
  endtask : rx_run
  task automatic wrap_up();
    $display("TB counts: %0d checks, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    int acks[$];
    int len;
    void'($urandom(11));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdreg(8'h00);
    `CHK("maxb rst", 32'h20, rd)
    rdreg(8'h04);
    `CHK("txlen rst", 32'h1, rd)
    rdreg(8'h14);
    `CHK("unmapped", 2'b10, rs)
    `CHK("unmapped data", 32'h0, rd)
    wr(8'h14, 32'h1);
    `CHK("unmapped wr", 2'b10, rs)
    $display("TEST reset done");
    wr(8'h00, 32'h2);
    `CHK("wr resp", 2'b00, rs)
    wr(8'h04, 32'h5);
    wr(8'h0C, 32'h1);
    tx_run('{0, 1});
    `CHK("tx_extra", 1'b1, tx_extra)
    rdreg(8'h10);
    `CHK("state extra", 32'h2, rd)
    fm_u.tx_send(1'b0, 1'b0);
    repeat (2) @(posedge aclk);
    `CHK("tx_extra end", 1'b0, tx_extra)
    chk_stat(tx_model(2, 5, '{0, 1, 0}));
    tx_run('{1, 0, 1});
    chk_stat(tx_model(2, 5, '{1, 0, 1}));
    repeat (8) begin
      acks = {};
      repeat (4) acks.push_back($urandom_range(1, 0));
      len = $urandom_range(3, 1);
      wr(8'h04, len);
      tx_run(acks);
      chk_stat(tx_model(2, len, acks));
    end
    `CHK("tx_end count", 10, tx_end_cnt)
    $display("TEST tx done");
    fm_u.rx_send(1'b1, 2'b00, 8'h04);
    fm_u.rx_send(1'b0, 2'b10, 8'h04);
    fm_u.rx_send(1'b0, 2'b01, 8'h04);
    repeat (2) @(posedge aclk);
    `CHK("rx_wait", 1'b1, rx_wait)
    repeat (2010) @(posedge aclk);
    `CHK("rx_wait end", 1'b0, rx_wait)
    chk_stat(rx_model(2, 4, '{2, 1}, 1'b1));
    rx_run('{0, 2}, 1'b1, 8'h04);
    rx_run('{1, 2, 0}, 1'b0, 8'h04);
    rx_run('{2, 1, 0}, 1'b0, 8'h04);
    rx_run('{0, 0, 0, 0}, 1'b0, 8'h04);
    rx_run('{0, 0}, 1'b0, 8'h02);
    $display("TEST rx done");
    wrap_up();
  end
endmodule : serial_bus_max_byte_overrun_tb
`default_nettype wire
